// >>> obf_defines.svh
// constants for the buffer-window hint port
`ifndef OBF_DEFINES_SVH
`define OBF_DEFINES_SVH
`define OBF_MSG_CODE 8'h12
`define OBF_TYPE_MSG 5'h14
`define OBF_FMT_NODATA 3'h1
`define OBF_TC_DEFAULT 3'h0
`define OBF_LEN_RSVD 10'h000
`define OBF_HINT_ACTIVE 4'hf
`define OBF_HINT_MEM 4'h1
`define OBF_HINT_IDLE 4'h0
`define OBF_EN_LSB 13
`define OBF_EN_MSB 14
`define OBF_EN_RESET 2'h0
`define OBF_EN_MSG_A 2'h1
`define OBF_EN_MSG_B 2'h2
`define OBF_EN_WAKE 2'h3
`define OBF_CLK_MHZ 50
`define OBF_PAIR_WIN_NS 1000
`define OBF_PAIR_WIN_CYC ((`OBF_PAIR_WIN_NS * `OBF_CLK_MHZ) / 1000)
`define OBF_WAKE_PULSE_NS 200
`define OBF_WAKE_PULSE_CYC ((`OBF_WAKE_PULSE_NS * `OBF_CLK_MHZ + 999) / 1000)
`endif

// >>> obf_pkg.sv
// types for the buffer-window hint port
`include "obf_defines.svh"
package obf_pkg;
	typedef enum logic [1:0] {
		OBF_EN_OFF = `OBF_EN_RESET,
		OBF_EN_A = `OBF_EN_MSG_A,
		OBF_EN_B = `OBF_EN_MSG_B,
		OBF_EN_WK = `OBF_EN_WAKE
	} obf_en_t;
	typedef enum logic [1:0] {
		OBF_WIN_IDLE = 2'b00,
		OBF_WIN_MEM = 2'b01,
		OBF_WIN_ACTIVE = 2'b11
	} obf_win_t;
	typedef enum logic [1:0] {
		OBF_TX_IDLE = 2'b00,
		OBF_TX_LINK = 2'b01,
		OBF_TX_SEND = 2'b10
	} obf_tx_t;
	typedef enum logic [1:0] {
		OBF_WK_STEADY = 2'b00,
		OBF_WK_HI = 2'b01,
		OBF_WK_LO = 2'b10
	} obf_wk_t;
	typedef enum logic [1:0] {
		OBF_DEC_QUIET = 2'b00,
		OBF_DEC_ONE = 2'b01,
		OBF_DEC_RISE = 2'b10
	} obf_dec_t;
endpackage

// >>> obf_wake_if.sv
// carrier between the hint port and its wake pattern decoder
interface obf_wake_if;
	import obf_pkg::*;
	logic clr;
	logic ev;
	obf_win_t ev_win;
	modport dec (input clr, output ev, output ev_win);
	modport port (output clr, input ev, input ev_win);
endinterface

// >>> obf_wake_decode.sv
// wake sideband falling- and rising-edge pattern decoder
`include "obf_defines.svh"
module obf_wake_decode import obf_pkg::*; #(
	parameter int PAIR_CYC = `OBF_PAIR_WIN_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_wake_n,
	obf_wake_if.dec bus
);
	if (PAIR_CYC < 2 || PAIR_CYC > 65535) begin : g_bad_pair
		$error("pair window out of range");
	end
	obf_dec_t st_reg;
	logic [15:0] cnt_reg;
	logic wake_d_reg;
	logic fall;
	logic rise;
	logic tmo;
	assign fall = wake_d_reg && !i_wake_n;
	assign rise = !wake_d_reg && i_wake_n;
	assign tmo = cnt_reg == 16'(PAIR_CYC - 1);
	////////////////////////////////////////////////////////////////
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wake_d_reg <= 1'b1;
		end else begin
			wake_d_reg <= i_wake_n;
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= OBF_DEC_QUIET;
			cnt_reg <= 16'h0000;
			bus.ev <= 1'b0;
			bus.ev_win <= OBF_WIN_ACTIVE;
		end else begin
			bus.ev <= 1'b0;
			cnt_reg <= cnt_reg + 16'h0001;
			if (bus.clr) begin
				st_reg <= OBF_DEC_QUIET;
				cnt_reg <= 16'h0000;
			end else begin
				unique case (st_reg)
					OBF_DEC_QUIET: begin
						cnt_reg <= 16'h0000;
						if (fall) begin
							st_reg <= OBF_DEC_ONE;
						end else if (rise) begin
							st_reg <= OBF_DEC_RISE;
						end
					end
					OBF_DEC_ONE: begin
						if (fall) begin
							st_reg <= OBF_DEC_QUIET;
							bus.ev <= 1'b1;
							bus.ev_win <= OBF_WIN_ACTIVE;
						end else if (tmo) begin
							st_reg <= OBF_DEC_QUIET;
							bus.ev <= 1'b1;
							bus.ev_win <= i_wake_n ? OBF_WIN_IDLE : OBF_WIN_MEM;
						end
					end
					OBF_DEC_RISE: begin
						if (fall) begin
							st_reg <= OBF_DEC_ONE;
							cnt_reg <= 16'h0000;
						end else if (tmo) begin
							st_reg <= OBF_DEC_QUIET;
							bus.ev <= 1'b1;
							bus.ev_win <= OBF_WIN_IDLE;
						end
					end
					default: begin
						st_reg <= OBF_DEC_QUIET;
					end
				endcase
			end
		end
	end
	sequence two_falls_s;
		st_reg == OBF_DEC_ONE && fall && !bus.clr;
	endsequence
	pair_active_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		two_falls_s |=> bus.ev && bus.ev_win == OBF_WIN_ACTIVE)
		else $error("two falls did not give active");
	single_mem_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		st_reg == OBF_DEC_ONE && tmo && !fall && !i_wake_n && !bus.clr
		|=> bus.ev && bus.ev_win == OBF_WIN_MEM)
		else $error("single fall did not give memory window");
endmodule // obf_wake_decode

// >>> obf_hint_port.sv
// buffer-window hint port: message check, wake decode, hint send
`include "obf_defines.svh"
module obf_hint_port import obf_pkg::*; #(
	parameter bit CAPABLE = 1'b1,
	parameter bit IS_DOWNSTREAM = 1'b0,
	parameter int PULSE_CYC = `OBF_WAKE_PULSE_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ctl_wr,
	input wire logic [15:0] i_ctl_wdata,
	input wire logic i_d0,
	input wire logic i_sys_s0,
	input wire logic i_wake_present,
	input wire logic i_fwd_en,
	input wire logic [15:0] i_port_id,
	input wire logic i_wake_n,
	output logic o_wake_o,
	output logic o_wake_oe_n,
	input wire logic i_rx_valid,
	input wire logic [2:0] i_rx_fmt,
	input wire logic [4:0] i_rx_type,
	input wire logic [2:0] i_rx_tc,
	input wire logic [7:0] i_rx_code,
	input wire logic [3:0] i_rx_hint,
	output logic o_rx_malformed,
	output logic o_rx_ur,
	input wire logic i_hint_req,
	input wire logic [3:0] i_hint_code,
	output logic o_fwd_valid,
	output logic [3:0] o_fwd_hint,
	input wire logic i_link_l0,
	output logic o_link_l0_req,
	output logic o_tx_valid,
	input wire logic i_tx_ready,
	output logic [2:0] o_tx_fmt,
	output logic [4:0] o_tx_type,
	output logic [2:0] o_tx_tc,
	output logic [9:0] o_tx_len,
	output logic [15:0] o_tx_req_id,
	output logic [7:0] o_tx_code,
	output logic [3:0] o_tx_hint,
	output logic [1:0] o_window,
	output logic [1:0] o_en_mode
);
	if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_bad_pulse
		$error("wake pulse count out of range");
	end
	////////////////////////////////////////////////////////////////
	// hint code helpers
	function automatic obf_win_t hint_to_win(input logic [3:0] h);
		obf_win_t w;
		w = OBF_WIN_ACTIVE;
		if (h == `OBF_HINT_MEM) begin
			w = OBF_WIN_MEM;
		end else if (h == `OBF_HINT_IDLE) begin
			w = OBF_WIN_IDLE;
		end
		return w;
	endfunction
	function automatic logic [3:0] win_to_hint(input obf_win_t w);
		logic [3:0] h;
		h = `OBF_HINT_ACTIVE;
		if (w == OBF_WIN_MEM) begin
			h = `OBF_HINT_MEM;
		end else if (w == OBF_WIN_IDLE) begin
			h = `OBF_HINT_IDLE;
		end
		return h;
	endfunction
	////////////////////////////////////////////////////////////////
	// enable field
	obf_en_t en_reg;
	obf_en_t en_next;
	logic en_on;
	logic msg_mode;
	logic wake_mode;
	logic arm;
	assign en_next = obf_en_t'(i_ctl_wdata[`OBF_EN_MSB:`OBF_EN_LSB]);
	assign en_on = en_reg != OBF_EN_OFF;
	assign msg_mode = en_reg == OBF_EN_A || en_reg == OBF_EN_B;
	assign wake_mode = en_reg == OBF_EN_WK;
	assign arm = i_ctl_wr && CAPABLE && en_reg == OBF_EN_OFF && en_next != OBF_EN_OFF;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			en_reg <= OBF_EN_OFF;
		end else if (i_ctl_wr) begin
			en_reg <= CAPABLE ? en_next : OBF_EN_OFF;
		end
	end
	assign o_en_mode = en_reg;
	////////////////////////////////////////////////////////////////
	// receive check
	logic rx_hit;
	logic rx_accept;
	obf_win_t rx_win;
	assign rx_hit = i_rx_valid && i_rx_fmt == `OBF_FMT_NODATA &&
		i_rx_type == `OBF_TYPE_MSG && i_rx_code == `OBF_MSG_CODE;
	assign rx_accept = rx_hit && CAPABLE && en_on && i_rx_tc == `OBF_TC_DEFAULT;
	assign rx_win = hint_to_win(i_rx_hint);
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rx_malformed <= 1'b0;
			o_rx_ur <= 1'b0;
		end else begin
			o_rx_ur <= rx_hit && !(CAPABLE && en_on);
			o_rx_malformed <= rx_hit && CAPABLE && en_on && i_rx_tc != `OBF_TC_DEFAULT;
		end
	end
	////////////////////////////////////////////////////////////////
	// wake decoder
	obf_wake_if wbus ();
	assign wbus.clr = arm || !wake_mode || IS_DOWNSTREAM;
	obf_wake_decode u_dec (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_wake_n(i_wake_n),
		.bus(wbus)
	);
	////////////////////////////////////////////////////////////////
	// current window
	obf_win_t win_reg;
	logic wk_ev;
	assign wk_ev = wbus.ev && wake_mode;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			win_reg <= OBF_WIN_ACTIVE;
		end else if (arm) begin
			win_reg <= OBF_WIN_ACTIVE;
		end else if (i_d0) begin
			if (rx_accept) begin
				win_reg <= rx_win;
			end else if (wk_ev) begin
				win_reg <= wbus.ev_win;
			end
		end
	end
	assign o_window = win_reg;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_fwd_valid <= 1'b0;
			o_fwd_hint <= `OBF_HINT_ACTIVE;
		end else begin
			o_fwd_valid <= i_fwd_en && i_d0 && (rx_accept || wk_ev);
			if (rx_accept) begin
				o_fwd_hint <= win_to_hint(rx_win);
			end else if (wk_ev) begin
				o_fwd_hint <= win_to_hint(wbus.ev_win);
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// message transmit
	obf_tx_t tx_st_reg;
	logic pend_reg;
	obf_win_t pend_win_reg;
	logic new_hint;
	assign new_hint = i_hint_req && IS_DOWNSTREAM && msg_mode && !i_wake_present;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pend_reg <= 1'b0;
			pend_win_reg <= OBF_WIN_ACTIVE;
		end else if (new_hint) begin
			pend_reg <= 1'b1;
			pend_win_reg <= hint_to_win(i_hint_code);
		end else if (tx_st_reg == OBF_TX_IDLE || !msg_mode) begin
			pend_reg <= 1'b0;
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_st_reg <= OBF_TX_IDLE;
			o_link_l0_req <= 1'b0;
			o_tx_valid <= 1'b0;
			o_tx_fmt <= `OBF_FMT_NODATA;
			o_tx_type <= `OBF_TYPE_MSG;
			o_tx_tc <= `OBF_TC_DEFAULT;
			o_tx_len <= `OBF_LEN_RSVD;
			o_tx_req_id <= 16'h0000;
			o_tx_code <= `OBF_MSG_CODE;
			o_tx_hint <= `OBF_HINT_ACTIVE;
		end else begin
			unique case (tx_st_reg)
				OBF_TX_IDLE: begin
					if (pend_reg && msg_mode) begin
						if (i_link_l0) begin
							tx_st_reg <= OBF_TX_SEND;
							o_tx_valid <= 1'b1;
							o_tx_fmt <= `OBF_FMT_NODATA;
							o_tx_type <= `OBF_TYPE_MSG;
							o_tx_len <= `OBF_LEN_RSVD;
							o_tx_tc <= `OBF_TC_DEFAULT;
							o_tx_req_id <= i_port_id;
							o_tx_code <= `OBF_MSG_CODE;
							o_tx_hint <= win_to_hint(pend_win_reg);
						end else if (en_reg == OBF_EN_B) begin
							tx_st_reg <= OBF_TX_LINK;
							o_link_l0_req <= 1'b1;
						end
					end
				end
				OBF_TX_LINK: begin
					if (!msg_mode) begin
						tx_st_reg <= OBF_TX_IDLE;
						o_link_l0_req <= 1'b0;
					end else if (i_link_l0) begin
						tx_st_reg <= OBF_TX_SEND;
						o_link_l0_req <= 1'b0;
						o_tx_valid <= 1'b1;
						o_tx_req_id <= i_port_id;
						o_tx_hint <= win_to_hint(pend_win_reg);
					end
				end
				OBF_TX_SEND: begin
					if (i_tx_ready) begin
						tx_st_reg <= OBF_TX_IDLE;
						o_tx_valid <= 1'b0;
					end
				end
				default: begin
					tx_st_reg <= OBF_TX_IDLE;
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// wake pattern drive
	obf_wk_t wk_st_reg;
	logic [7:0] wk_cnt_reg;
	logic [1:0] wk_falls_reg;
	logic wk_go;
	logic wk_done;
	assign wk_go = i_hint_req && IS_DOWNSTREAM && wake_mode && i_sys_s0;
	assign wk_done = wk_cnt_reg == 8'(PULSE_CYC - 1);
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wk_st_reg <= OBF_WK_STEADY;
			wk_cnt_reg <= 8'h00;
			wk_falls_reg <= 2'h0;
			o_wake_oe_n <= 1'b1;
			o_wake_o <= 1'b0;
		end else begin
			o_wake_o <= 1'b0;
			wk_cnt_reg <= wk_cnt_reg + 8'h01;
			if (!wake_mode) begin
				wk_st_reg <= OBF_WK_STEADY;
				o_wake_oe_n <= 1'b1;
			end else if (wk_go) begin
				wk_cnt_reg <= 8'h00;
				if (hint_to_win(i_hint_code) == OBF_WIN_IDLE) begin
					wk_st_reg <= OBF_WK_STEADY;
					o_wake_oe_n <= 1'b1;
				end else begin
					wk_st_reg <= OBF_WK_HI;
					o_wake_oe_n <= 1'b1;
					wk_falls_reg <= hint_to_win(i_hint_code) == OBF_WIN_MEM ? 2'h1 : 2'h2;
				end
			end else begin
				unique case (wk_st_reg)
					OBF_WK_STEADY: begin
						wk_cnt_reg <= 8'h00;
					end
					OBF_WK_HI: begin
						if (wk_done) begin
							wk_cnt_reg <= 8'h00;
							o_wake_oe_n <= 1'b0;
							wk_falls_reg <= wk_falls_reg - 2'h1;
							wk_st_reg <= wk_falls_reg == 2'h1 ? OBF_WK_STEADY : OBF_WK_LO;
						end
					end
					OBF_WK_LO: begin
						if (wk_done) begin
							wk_cnt_reg <= 8'h00;
							o_wake_oe_n <= 1'b1;
							wk_st_reg <= OBF_WK_HI;
						end
					end
					default: begin
						wk_st_reg <= OBF_WK_STEADY;
					end
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// checks
	sequence hint_ok_s;
		rx_accept && i_d0 && !arm;
	endsequence
	tx_header_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_tx_valid |-> o_tx_fmt == `OBF_FMT_NODATA && o_tx_type == `OBF_TYPE_MSG
		&& o_tx_len == `OBF_LEN_RSVD && o_tx_code == `OBF_MSG_CODE)
		else $error("bad hint message header");
	tx_class_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_tx_valid |-> o_tx_tc == `OBF_TC_DEFAULT)
		else $error("hint sent on non-default class");
	tx_reqid_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_tx_valid) |-> o_tx_req_id == $past(i_port_id))
		else $error("requester id not port id");
	rx_malformed_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		rx_hit && en_on && i_rx_tc != `OBF_TC_DEFAULT |=> o_rx_malformed && !o_rx_ur)
		else $error("bad class not flagged malformed");
	rx_unsup_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		rx_hit && !en_on && !arm |=> o_rx_ur && o_window == $past(o_window))
		else $error("disabled hint not flagged UR");
	rsvd_active_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		hint_ok_s and (i_rx_hint != `OBF_HINT_MEM && i_rx_hint != `OBF_HINT_IDLE)
		|=> o_window == OBF_WIN_ACTIVE)
		else $error("reserved code not treated as active");
	d0_ignore_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!i_d0 && !arm |=> $stable(o_window))
		else $error("window moved outside D0");
	arm_active_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		arm |=> o_window == OBF_WIN_ACTIVE && o_en_mode != OBF_EN_OFF)
		else $error("first enable did not assume active");
	mode_a_drop_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		tx_st_reg == OBF_TX_IDLE && pend_reg && en_reg == OBF_EN_A && !i_link_l0
		|=> !o_tx_valid && !o_link_l0_req)
		else $error("mode A did not drop off L0");
	upstream_quiet_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!IS_DOWNSTREAM |-> !o_tx_valid && o_wake_oe_n)
		else $error("upstream port transmitted a hint");
endmodule // obf_hint_port

// >>> obf_link_partner.sv
// link partner model: hint sender, transmit sink, link power state
`include "obf_defines.svh"
module obf_link_partner (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_tx_valid,
	input wire logic i_link_l0_req,
	output logic o_rx_valid,
	output logic [2:0] o_rx_fmt,
	output logic [4:0] o_rx_type,
	output logic [2:0] o_rx_tc,
	output logic [7:0] o_rx_code,
	output logic [3:0] o_rx_hint,
	output logic o_tx_ready,
	output logic o_link_l0
);
	timeunit 1ns;
	timeprecision 1ps;
	int acc_cnt = 0;
	int lag = 0;
	int wake_cnt = 0;
	initial begin
		o_rx_valid = 1'b0;
		{o_rx_fmt, o_rx_type, o_rx_tc, o_rx_code, o_rx_hint} = 23'h5a5a5a;
		o_link_l0 = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// downstream hint header
	task automatic send_hint(input logic [2:0] tc, input logic [3:0] hint);
		@(posedge i_core_clk);
		o_rx_valid <= 1'b1;
		o_rx_fmt <= `OBF_FMT_NODATA;
		o_rx_type <= `OBF_TYPE_MSG;
		o_rx_tc <= tc;
		o_rx_code <= `OBF_MSG_CODE;
		o_rx_hint <= hint;
		@(posedge i_core_clk);
		o_rx_valid <= 1'b0;
		{o_rx_fmt, o_rx_type, o_rx_tc, o_rx_code, o_rx_hint} <=
			~{o_rx_fmt, o_rx_type, o_rx_tc, o_rx_code, o_rx_hint};
	endtask
	////////////////////////////////////////////////////////////////
	// sink: answers promptly and slowly by turns
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			acc_cnt <= 0;
			o_tx_ready <= 1'b0;
		end else begin
			acc_cnt <= i_tx_valid ? acc_cnt + 1 : 0;
			o_tx_ready <= i_tx_valid && acc_cnt == lag;
			if (i_tx_valid && acc_cnt == lag) begin
				lag <= (lag == 0) ? 3 : 0;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// link returns to L0 a few cycles after being asked
	always @(posedge i_core_clk) begin
		wake_cnt <= (i_link_l0_req && !o_link_l0) ? wake_cnt + 1 : 0;
		if (wake_cnt == 4) begin
			o_link_l0 <= 1'b1;
		end
	end
	task automatic leave_l0;
		@(posedge i_core_clk);
		o_link_l0 <= 1'b0;
	endtask
endmodule // obf_link_partner

// >>> obf_indication_logic_tb_top.sv
// testbench for the buffer-window hint port
`include "obf_defines.svh"
module obf_indication_logic_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] tc;
		logic [3:0] hint;
		logic d0;
		logic [1:0] win;
		logic ur;
		logic mal;
		logic fwd;
		logic [3:0] fhint;
	} obf_row_t;
	obf_row_t rows [9] = '{
		'{2'h1, 3'h0, 4'h1, 1'b1, 2'h1, 1'b0, 1'b0, 1'b1, 4'h1},
		'{2'h1, 3'h0, 4'h0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 4'h0},
		'{2'h1, 3'h0, 4'h5, 1'b1, 2'h3, 1'b0, 1'b0, 1'b1, 4'hf},
		'{2'h2, 3'h0, 4'h0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 4'h0},
		'{2'h2, 3'h3, 4'h1, 1'b1, 2'h0, 1'b0, 1'b1, 1'b0, 4'h0},
		'{2'h1, 3'h0, 4'h1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 4'h0},
		'{2'h0, 3'h0, 4'hf, 1'b1, 2'h0, 1'b1, 1'b0, 1'b0, 4'h0},
		'{2'h1, 3'h0, 4'h0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 4'h0},
		'{2'h1, 3'h0, 4'h8, 1'b1, 2'h3, 1'b0, 1'b0, 1'b1, 4'hf}
	};
	// hint, falls on the wire, window at the receiver
	logic [11:0] wk [3] = '{12'h111, 12'hf23, 12'h000};
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_ctl_wr = 1'b0;
	logic [15:0] i_ctl_wdata = 16'h0000;
	logic i_d0 = 1'b1, i_sys_s0 = 1'b1, i_wake_present = 1'b0, i_fwd_en = 1'b1;
	logic [15:0] i_port_id = 16'h3c5a;
	logic i_hint_req = 1'b0;
	logic [3:0] i_hint_code = 4'h0;
	logic i_wake_n, o_wake_o, o_wake_oe_n, tx_wake_o, tx_oe_n;
	logic i_rx_valid, i_tx_ready, i_link_l0, o_rx_malformed, o_rx_ur, o_fwd_valid;
	logic [2:0] i_rx_fmt, i_rx_tc, o_tx_fmt, o_tx_tc, tx_fmt, tx_tc;
	logic [4:0] i_rx_type, o_tx_type, tx_type;
	logic [7:0] i_rx_code, o_tx_code, tx_code;
	logic [3:0] i_rx_hint, o_fwd_hint, o_tx_hint, tx_hint;
	logic [9:0] o_tx_len, tx_len;
	logic [15:0] o_tx_req_id, tx_req_id;
	logic o_link_l0_req, o_tx_valid, tx_l0_req, tx_valid;
	logic [1:0] o_window, o_en_mode;
	logic [2:0] mon;
	int miscompares = 0, num_checks = 0, cycles = 0, falls = 0, up_tx = 0;
	////////////////////////////////////////////////////////////////
	always #10 i_core_clk = ~i_core_clk;
	// open-drain wake line with pull-up
	assign i_wake_n = ((!o_wake_oe_n && !o_wake_o) || (!tx_oe_n && !tx_wake_o)) ? 1'b0 : 1'b1;
	assign mon = {tx_l0_req, tx_valid, ~tx_valid};
	obf_hint_port #(.CAPABLE(1'b1), .IS_DOWNSTREAM(1'b0), .PULSE_CYC(10)) dut (.*);
	obf_hint_port #(.CAPABLE(1'b1), .IS_DOWNSTREAM(1'b1), .PULSE_CYC(10)) dut_tx (.*,
		.o_wake_o(tx_wake_o), .o_wake_oe_n(tx_oe_n), .o_rx_malformed(), .o_rx_ur(),
		.o_fwd_valid(), .o_fwd_hint(), .o_link_l0_req(tx_l0_req), .o_tx_valid(tx_valid),
		.o_tx_fmt(tx_fmt), .o_tx_type(tx_type), .o_tx_tc(tx_tc), .o_tx_len(tx_len),
		.o_tx_req_id(tx_req_id), .o_tx_code(tx_code), .o_tx_hint(tx_hint),
		.o_window(), .o_en_mode());
	obf_link_partner lp (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_tx_valid(tx_valid),
		.i_link_l0_req(tx_l0_req), .o_rx_valid(i_rx_valid), .o_rx_fmt(i_rx_fmt),
		.o_rx_type(i_rx_type), .o_rx_tc(i_rx_tc), .o_rx_code(i_rx_code),
		.o_rx_hint(i_rx_hint), .o_tx_ready(i_tx_ready), .o_link_l0(i_link_l0));
	always @(negedge i_wake_n) falls++;
	always @(posedge i_core_clk) begin
		cycles++;
		if (o_tx_valid === 1'b1) up_tx++;
		if (cycles == 4000) begin
			miscompares++;
			$display("timeout after %0d cycles", cycles);
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cfg(input logic [1:0] mode);
		@(posedge i_core_clk);
		i_ctl_wr <= 1'b1;
		i_ctl_wdata <= {1'b1, mode, 13'h1fff};
		@(posedge i_core_clk);
		i_ctl_wr <= 1'b0;
		@(negedge i_core_clk);
		chk("en_mode", 16'(o_en_mode), 16'(mode));
	endtask
	task automatic send_req(input logic [3:0] code);
		@(posedge i_core_clk);
		i_hint_req <= 1'b1;
		i_hint_code <= code;
		@(posedge i_core_clk);
		i_hint_req <= 1'b0;
	endtask
	task automatic watch(input int n, input int idx, output logic hit);
		hit = 1'b0;
		repeat (n) begin
			@(negedge i_core_clk);
			if (mon[idx] === 1'b1) begin
				hit = 1'b1;
				break;
			end
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		obf_row_t r;
		logic hit;
		logic [1:0] prev;
		int f0;
		repeat (12) @(posedge i_core_clk);
		i_rst <= 1'b0;
		@(negedge i_core_clk);
		chk("rst_window", 16'(o_window), 16'h0003);
		chk("rst_en_mode", 16'(o_en_mode), 16'h0000);
		chk("rst_oe_n", 16'(tx_oe_n), 16'h0001);
		chk("rst_tx_valid", 16'(tx_valid), 16'h0000);
		$display("reset test done");
		prev = 2'h0;
		foreach (rows[k]) begin
			r = rows[k];
			cfg(r.mode);
			if (prev == 2'h0 && r.mode != 2'h0) chk("first_en", 16'(o_window), 16'h0003);
			prev = r.mode;
			@(posedge i_core_clk);
			i_d0 <= r.d0;
			lp.send_hint(r.tc, r.hint);
			@(negedge i_core_clk);
			chk("window", 16'(o_window), 16'(r.win));
			chk("ur", 16'(o_rx_ur), 16'(r.ur));
			chk("malformed", 16'(o_rx_malformed), 16'(r.mal));
			chk("fwd_valid", 16'(o_fwd_valid), 16'(r.fwd));
			if (r.fwd) chk("fwd_hint", 16'(o_fwd_hint), 16'(r.fhint));
		end
		@(posedge i_core_clk);
		i_d0 <= 1'b1;
		i_fwd_en <= 1'b0;
		lp.send_hint(3'h0, 4'h1);
		@(negedge i_core_clk);
		chk("fwd_off", 16'(o_fwd_valid), 16'h0000);
		chk("window_fwd_off", 16'(o_window), 16'h0001);
		@(posedge i_core_clk);
		i_fwd_en <= 1'b1;
		$display("receive table done");
		cfg(2'h1);
		send_req(4'h1);
		watch(8, 1, hit);
		chk("tx_in_l0", 16'(hit), 16'h0001);
		chk("tx_fmt", 16'(tx_fmt), 16'(`OBF_FMT_NODATA));
		chk("tx_type", 16'(tx_type), 16'(`OBF_TYPE_MSG));
		chk("tx_len", 16'(tx_len), 16'h0000);
		chk("tx_req_id", tx_req_id, i_port_id);
		chk("tx_tc", 16'(tx_tc), 16'h0000);
		chk("tx_code", 16'(tx_code), 16'h0012);
		chk("tx_hint", 16'(tx_hint), 16'h0001);
		watch(10, 0, hit);
		chk("tx_release", 16'(hit), 16'h0001);
		lp.leave_l0();
		send_req(4'h0);
		watch(10, 1, hit);
		chk("drop_off_l0", 16'(hit), 16'h0000);
		@(posedge i_core_clk);
		i_port_id <= 16'h1e2d;
		cfg(2'h2);
		send_req(4'hf);
		watch(8, 2, hit);
		chk("l0_request", 16'(hit), 16'h0001);
		watch(12, 1, hit);
		chk("tx_after_l0", 16'(hit), 16'h0001);
		chk("l0_req_drop", 16'(tx_l0_req), 16'h0000);
		chk("tx_hint_b", 16'(tx_hint), 16'h000f);
		chk("tx_req_id_b", tx_req_id, 16'h1e2d);
		watch(12, 0, hit);
		chk("tx_release_b", 16'(hit), 16'h0001);
		@(posedge i_core_clk);
		i_wake_present <= 1'b1;
		send_req(4'h1);
		watch(10, 1, hit);
		chk("msg_with_wake", 16'(hit), 16'h0000);
		$display("message send tests done");
		cfg(2'h0);
		cfg(2'h3);
		chk("wake_first", 16'(o_window), 16'h0003);
		foreach (wk[k]) begin
			f0 = falls;
			send_req(wk[k][11:8]);
			// each window held just past 10us (520 cycles of 20ns, 10.4us)
			repeat (520) @(negedge i_core_clk);
			chk("wake_falls", 16'(falls - f0), 16'(wk[k][7:4]));
			chk("wake_window", 16'(o_window), 16'(wk[k][3:0]));
		end
		@(posedge i_core_clk);
		i_sys_s0 <= 1'b0;
		f0 = falls;
		send_req(4'hf);
		repeat (60) @(negedge i_core_clk);
		chk("wake_off_s0", 16'(falls - f0), 16'h0000);
		chk("oe_off_s0", 16'(tx_oe_n), 16'h0001);
		chk("upstream_tx", 16'(up_tx), 16'h0000);
		chk("up_oe_n", 16'(o_wake_oe_n), 16'h0001);
		chk("up_l0_req", 16'(o_link_l0_req), 16'h0000);
		$display("wake tests done");
		@(posedge i_core_clk);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		i_rst <= 1'b0;
		@(negedge i_core_clk);
		chk("rerst_window", 16'(o_window), 16'h0003);
		chk("rerst_en_mode", 16'(o_en_mode), 16'h0000);
		chk("rerst_oe_n", 16'(tx_oe_n), 16'h0001);
		$display("mid-run reset test done");
		wrap_up();
	end
endmodule // obf_indication_logic_tb_top
